/* File: rtl/abd_decider.sv */
/*
 * Ambient zone backlight decider with its AHB-Lite register slave.
 * Assumes the averager reports the zone of the period just completed with a one-cycle
 * periodTick and follows the fastStart output for its period length.
 */
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
module abd_decider #(
    parameter int FAST_PERIOD_CYC = abd_pkg::FAST_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire abd_pkg::abd_ahb_req_t ahbReq,
    input  wire logic                  hready,
    output abd_pkg::abd_ahb_rsp_t      ahbRsp,
    input  wire abd_pkg::abd_avg_t     avgIn,
    output logic                       fastStart,
    output logic [abd_pkg::ZW-1:0]     avgZone,
    output logic [abd_pkg::ZW-1:0]     targetZone,
    output logic [abd_pkg::TW-1:0]     backlightTarget,
    input  wire logic                  zoneIrqNIn,
    output logic                       zoneIrqNOut,
    output logic                       zoneIrqNOe
);
    import abd_pkg::*;

    localparam logic [TMRW-1:0] FAST_LAST  = TMRW'(FAST_PERIOD_CYC - 1);
    localparam logic [1:0]      FAST_LASTP = 2'(FAST_PERIODS - 1);

    if (FAST_PERIOD_CYC < 2 || FAST_PERIOD_CYC >= 2 ** TMRW) begin : g_bad_fast
        $error("abd_decider: fast period count out of range");
    end

    abd_state_t      state_r;
    abd_state_t      state_nxt;
    logic            dataPh;
    logic            rdWaitNow;
    logic            hreadyOut;
    logic            newReq;
    logic            rdTaken;
    logic            irqEvt;
    logic            bound;
    logic            goUp;
    logic            goDn;
    abd_dir_t        newDir;
    logic [CNTW-1:0] needQ;
    logic [CNTW-1:0] cntInc;
    logic [31:0]     rdVal;
    logic            memWe;
    logic [ZW-1:0]   memWaddr;
    logic [ZW-1:0]   memRaddrA;
    logic [TW-1:0]   memRdA;

    function automatic logic isTgt(input logic [AW-1:0] a);
        return a >= OFF_TGT0 && a <= OFF_TGT4 && a[1:0] == 2'b00;
    endfunction

    function automatic logic [ZW-1:0] tgtIdx(input logic [AW-1:0] a);
        logic [AW-1:0] d;
        d = a - OFF_TGT0;
        return d[ZW+1:2];
    endfunction

    // Reads take one wait state so that hrdata always comes from a flip-flop.
    assign dataPh    = state_r.aValid;
    assign rdWaitNow = dataPh && !state_r.aWrite && state_r.rdWait;
    assign hreadyOut = !rdWaitNow;
    assign newReq    = ahbReq.hsel && ahbReq.htrans[1] && hready;
    assign rdTaken   = dataPh && !state_r.aWrite && !state_r.rdWait;
    assign memRaddrA = tgtIdx(ahbReq.haddr[AW-1:0]);
    assign memWaddr  = tgtIdx(state_r.aAddr);
    assign memWe     = dataPh && state_r.aWrite && isTgt(state_r.aAddr);

    assign irqEvt = state_r.enable && (avgIn.zone != state_r.runZone);
    assign bound  = (state_r.st == ST_RUN && avgIn.periodTick)
                 || (state_r.st == ST_FAST && state_r.tmr == FAST_LAST);
    assign goUp   = avgIn.zone > state_r.avgOut;
    assign goDn   = avgIn.zone < state_r.avgOut;
    assign newDir = goUp ? DIR_UP : DIR_DN;
    assign cntInc = CNTW'(state_r.cnt + 1'b1);
    // Downward qualification in down-delay mode is 3 + (3 + code) periods.
    assign needQ  = (state_r.downEn && state_r.pend == DIR_DN)
                  ? CNTW'(BASE_QUAL + DLY_EXTRA_BASE) + CNTW'(state_r.dlyCode)
                  : CNTW'(BASE_QUAL);

    always_comb
    begin
        rdVal = '0;
        if (state_r.aAddr == OFF_CTRL)
        begin
            rdVal[CTRL_EN_BIT] = state_r.enable;
            rdVal[CTRL_DD_BIT] = state_r.downEn;
        end
        else if (state_r.aAddr == OFF_DLY)
        begin
            rdVal[DLYW-1:0] = state_r.dlyCode;
        end
        else if (state_r.aAddr == OFF_INFO)
        begin
            rdVal[ZW-1:0]        = state_r.infoZone;
            rdVal[INFO_FLAG_BIT] = state_r.flag;
        end
        else if (state_r.aAddr == OFF_STAT)
        begin
            rdVal[STAT_AVG_LSB +: ZW] = state_r.avgOut;
            rdVal[STAT_RUN_LSB +: ZW] = state_r.runZone;
            rdVal[STAT_TGT_LSB +: ZW] = state_r.tgtZone;
            rdVal[STAT_FAST_BIT]      = state_r.st == ST_FAST;
            rdVal[STAT_ARM_BIT]       = state_r.armed;
            rdVal[STAT_PIN_BIT]       = zoneIrqNIn;
        end
        else if (isTgt(state_r.aAddr))
        begin
            rdVal[TW-1:0] = memRdA;
        end
    end

    always_comb
    begin
        state_nxt         = state_r;
        state_nxt.runZone = avgIn.zone;
        if (rdWaitNow)
        begin
            state_nxt.rdata  = rdVal;
            state_nxt.rdWait = 1'b0;
        end
        if (hreadyOut)
        begin
            state_nxt.aValid = newReq;
            state_nxt.aWrite = ahbReq.hwrite;
            state_nxt.aAddr  = ahbReq.haddr[AW-1:0];
            state_nxt.rdWait = newReq && !ahbReq.hwrite;
        end
        if (dataPh && state_r.aWrite)
        begin
            if (state_r.aAddr == OFF_CTRL)
            begin
                state_nxt.enable = ahbReq.hwdata[CTRL_EN_BIT];
                state_nxt.downEn = ahbReq.hwdata[CTRL_DD_BIT];
            end
            else if (state_r.aAddr == OFF_DLY)
            begin
                state_nxt.dlyCode = ahbReq.hwdata[DLYW-1:0];
            end
        end

        // A zone entry in the same cycle as the clearing read keeps the flag set.
        if (rdTaken && state_r.aAddr == OFF_INFO)
        begin
            state_nxt.flag = 1'b0;
        end
        if (irqEvt)
        begin
            state_nxt.flag     = 1'b1;
            state_nxt.infoZone = avgIn.zone;
        end

        case (state_r.st)
            ST_OFF:
            begin
                if (state_r.enable)
                begin
                    state_nxt.st      = ST_FAST;
                    state_nxt.avgOut  = '0;
                    state_nxt.tgtZone = '0;
                    state_nxt.tmr     = '0;
                    state_nxt.fastCnt = '0;
                    state_nxt.pend    = DIR_NONE;
                    state_nxt.last    = DIR_NONE;
                    state_nxt.armed   = 1'b0;
                    state_nxt.cnt     = '0;
                end
            end
            ST_FAST:
            begin
                state_nxt.tmr = TMRW'(state_r.tmr + 1'b1);
                if (bound)
                begin
                    state_nxt.tmr     = '0;
                    state_nxt.avgOut  = avgIn.zone;
                    state_nxt.fastCnt = 2'(state_r.fastCnt + 1'b1);
                    if (state_r.fastCnt == FAST_LASTP)
                    begin
                        state_nxt.st      = ST_RUN;
                        state_nxt.tgtZone = avgIn.zone;
                    end
                end
            end
            ST_RUN:
            begin
                // The target only ever moves on a period boundary.
                if (bound)
                begin
                    state_nxt.avgOut = avgIn.zone;
                    if (state_r.armed)
                    begin
                        state_nxt.armed = 1'b0;
                        state_nxt.pend  = DIR_NONE;
                        state_nxt.cnt   = '0;
                        if ((goUp || goDn) && newDir == state_r.last)
                        begin
                            state_nxt.tgtZone = avgIn.zone;
                            state_nxt.armed   = 1'b1;
                        end
                        else if (goUp || goDn)
                        begin
                            state_nxt.pend = newDir;
                            state_nxt.cnt  = CNTW'(1);
                        end
                    end
                    else if (state_r.pend == DIR_NONE)
                    begin
                        if (goUp || goDn)
                        begin
                            state_nxt.pend = newDir;
                            state_nxt.cnt  = CNTW'(1);
                        end
                    end
                    else if ((goUp || goDn) && newDir != state_r.pend)
                    begin
                        state_nxt.pend = newDir;
                        state_nxt.cnt  = CNTW'(1);
                    end
                    else
                    begin
                        state_nxt.cnt = cntInc;
                        if (cntInc >= needQ)
                        begin
                            state_nxt.tgtZone = avgIn.zone;
                            state_nxt.armed   = 1'b1;
                            state_nxt.last    = state_r.pend;
                            state_nxt.pend    = DIR_NONE;
                            state_nxt.cnt     = '0;
                        end
                    end
                end
            end
            default:
            begin
                state_nxt.st = ST_OFF;
            end
        endcase
        if (!state_r.enable)
        begin
            state_nxt.st = ST_OFF;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r      <= '0;
            state_r.st   <= ST_OFF;
            state_r.pend <= DIR_NONE;
            state_r.last <= DIR_NONE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    abd_target_mem #(
        .WIDTH (TW),
        .DEPTH (NUM_ZONES)
    ) u_mem (
        .clk    (clk),
        .rst_n  (rst_n),
        .we     (memWe),
        .waddr  (memWaddr),
        .wdata  (ahbReq.hwdata[TW-1:0]),
        .raddrA (memRaddrA),
        .rdataA (memRdA),
        .raddrB (state_r.tgtZone),
        .rdataB (backlightTarget)
    );

    assign ahbRsp.hreadyout = hreadyOut;
    assign ahbRsp.hresp     = 1'b0;
    assign ahbRsp.hrdata    = state_r.rdata;
    assign fastStart        = state_r.st == ST_FAST;
    assign avgZone          = state_r.avgOut;
    assign targetZone       = state_r.tgtZone;
    assign zoneIrqNOut      = 1'b0;
    assign zoneIrqNOe       = state_r.flag;

    logic [19:0] fastLen;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fastLen <= '0;
        end
        else
        begin
            fastLen <= fastStart ? 20'(fastLen + 1'b1) : '0;
        end
    end

    default clocking cbDef @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_fast_start_len: assert property (
        $fell(fastStart) && state_r.st == ST_RUN |-> fastLen == 20'(FAST_PERIODS * FAST_PERIOD_CYC))
        else $error("fast start length wrong");
    a_start_zone_zero: assert property (
        $rose(fastStart) |-> targetZone == '0 && avgZone == '0)
        else $error("start zone not zero");
    a_avg_out_update: assert property (
        state_r.st == ST_RUN && avgIn.periodTick && state_r.enable |=> avgZone == $past(avgIn.zone))
        else $error("averager output not updated");
    a_target_at_bound: assert property (
        state_r.st == ST_RUN && !avgIn.periodTick |=> $stable(targetZone))
        else $error("target moved mid period");
    a_direct_down_move: assert property (
        state_r.enable && !state_r.armed && !state_r.downEn && state_r.pend == DIR_DN && state_r.cnt == 2
        && bound && state_r.st == ST_RUN && !goUp |=> targetZone == $past(avgIn.zone))
        else $error("direct down move missed");
    a_follow_same_dir: assert property (
        state_r.enable && state_r.armed && bound && state_r.st == ST_RUN && state_r.last == DIR_DN && goDn
        |=> targetZone == $past(avgIn.zone) && state_r.armed)
        else $error("same direction follow missed");
    a_opposite_hold: assert property (
        state_r.enable && state_r.armed && bound && state_r.st == ST_RUN && state_r.last == DIR_UP && goDn
        |=> $stable(targetZone) && !state_r.armed)
        else $error("opposite change moved target");
    a_up_no_delay: assert property (
        state_r.enable && state_r.downEn && !state_r.armed && state_r.pend == DIR_UP && state_r.cnt == 2
        && bound && state_r.st == ST_RUN && !goDn |=> targetZone == $past(avgIn.zone))
        else $error("up move delayed");
    a_down_delay_hold: assert property (
        state_r.downEn && state_r.pend == DIR_DN && state_r.cnt < CNTW'(5) + CNTW'(state_r.dlyCode)
        && bound && state_r.st == ST_RUN |=> $stable(targetZone))
        else $error("down move before delay");
    a_irq_set: assert property (
        irqEvt |=> zoneIrqNOe && state_r.infoZone == $past(avgIn.zone))
        else $error("interrupt not raised");
    a_irq_clear: assert property (
        rdTaken && state_r.aAddr == OFF_INFO && !irqEvt |=> !zoneIrqNOe)
        else $error("read did not clear interrupt");

    c_fast_done: cover property ($fell(fastStart) && state_r.st == ST_RUN);
    c_down_delay_move: cover property (state_r.downEn && state_r.pend == DIR_DN ##1 state_r.last == DIR_DN);
    c_up_move: cover property (state_r.pend == DIR_UP ##1 state_r.armed && state_r.last == DIR_UP);
    c_irq_cycle: cover property ($rose(zoneIrqNOe) ##[1:50] $fell(zoneIrqNOe));
endmodule // abd_decider

/* File: rtl/abd_pkg.sv */
/*
 * Shared constants, types and register map of the ambient zone backlight decider.
 * Assumes a 125 MHz system clock and an averager that reports one zone per period.
 */
// What this block does
// - Direct mode moves the backlight target up or down under shared qualification.
// - On enable, run three fast 1.1 ms periods to settle the averager output.
// - Keep the running period zone and the last completed period zone.
// - A downward change qualifies on the third period since leaving the start zone.
// - Once qualified, a further same-direction change moves the target at once.
// - An opposite change holds the target and demands full requalification.
// - An upward change qualifies on the third period, staying high counts too.
// - Down-delay mode adds programmable extra periods before a downward change qualifies.
// - Five-bit delay code: 00000 adds three periods, each step one more.
// - Down-delay downward move needs three periods plus the extra delay.
// - A rise before the down delay ends cancels the pending decrease.
// - Upward moves in down-delay mode still qualify after three periods.
// - The down count starts at the first drop; target applies at period start.
// - While enabled, pull the open-drain interrupt low on entering a new zone.
// - On interrupt, store the current zone and set the flag at bit 3.
// - Reading the zone information register clears the flag and releases the pin.
// - The target changes only at the boundary of an averaging period.
// - The averager output starts at zone 0 before the fast periods run.
// - The new target is the configured brightness of the averager output zone.
package abd_pkg;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int FAST_PERIOD_NS = 1100000;
    localparam int FAST_CYCLES    = FAST_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FAST_PERIODS   = 3;
    localparam int BASE_QUAL      = 3;
    localparam int DLY_EXTRA_BASE = 3;

    localparam int ZW   = 3;
    localparam int TW   = 8;
    localparam int DLYW = 5;
    localparam int CNTW = 6;
    localparam int TMRW = 18;
    localparam int AW   = 6;
    localparam int NUM_ZONES = 5;

    localparam logic [AW-1:0] OFF_CTRL = 6'h00;
    localparam logic [AW-1:0] OFF_DLY  = 6'h04;
    localparam logic [AW-1:0] OFF_INFO = 6'h08;
    localparam logic [AW-1:0] OFF_STAT = 6'h0c;
    localparam logic [AW-1:0] OFF_TGT0 = 6'h10;
    localparam logic [AW-1:0] OFF_TGT4 = 6'h20;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_DD_BIT   = 1;
    localparam int INFO_FLAG_BIT = 3;
    localparam int STAT_AVG_LSB  = 0;
    localparam int STAT_RUN_LSB  = 4;
    localparam int STAT_TGT_LSB  = 8;
    localparam int STAT_FAST_BIT = 12;
    localparam int STAT_ARM_BIT  = 13;
    localparam int STAT_PIN_BIT  = 14;

    localparam logic [39:0] TGT_RST = 40'hff_cc_99_66_33;

    typedef enum logic [2:0] {ST_OFF = 3'b001, ST_FAST = 3'b010, ST_RUN = 3'b100} abd_mode_t;
    typedef enum logic [2:0] {DIR_NONE = 3'b001, DIR_UP = 3'b010, DIR_DN = 3'b100} abd_dir_t;

    typedef struct packed {
        logic          hsel;
        logic [31:0]   haddr;
        logic [1:0]    htrans;
        logic          hwrite;
        logic [2:0]    hsize;
        logic [31:0]   hwdata;
    } abd_ahb_req_t;

    typedef struct packed {
        logic          hreadyout;
        logic          hresp;
        logic [31:0]   hrdata;
    } abd_ahb_rsp_t;

    typedef struct packed {
        logic          periodTick;
        logic [ZW-1:0] zone;
    } abd_avg_t;

    typedef struct packed {
        abd_mode_t       st;
        abd_dir_t        pend;
        abd_dir_t        last;
        logic            armed;
        logic [CNTW-1:0] cnt;
        logic [ZW-1:0]   avgOut;
        logic [ZW-1:0]   runZone;
        logic [ZW-1:0]   tgtZone;
        logic [ZW-1:0]   infoZone;
        logic            flag;
        logic [1:0]      fastCnt;
        logic [TMRW-1:0] tmr;
        logic            enable;
        logic            downEn;
        logic [DLYW-1:0] dlyCode;
        logic            aValid;
        logic            aWrite;
        logic [AW-1:0]   aAddr;
        logic            rdWait;
        logic [31:0]     rdata;
    } abd_state_t;
endpackage

/* File: rtl/abd_target_mem.sv */
/*
 * Zone brightness target store: one write port and two registered read ports.
 * Assumes the bus side and the decider side read independently every cycle.
 */
`timescale 1ns/10ps
module abd_target_mem #(
    parameter int WIDTH = abd_pkg::TW,
    parameter int DEPTH = abd_pkg::NUM_ZONES
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  we,
    input  wire logic [abd_pkg::ZW-1:0] waddr,
    input  wire logic [WIDTH-1:0]      wdata,
    input  wire logic [abd_pkg::ZW-1:0] raddrA,
    output logic      [WIDTH-1:0]      rdataA,
    input  wire logic [abd_pkg::ZW-1:0] raddrB,
    output logic      [WIDTH-1:0]      rdataB
);
    import abd_pkg::*;

    typedef struct packed {
        logic [DEPTH*WIDTH-1:0] mem;
        logic [WIDTH-1:0]       rdA;
        logic [WIDTH-1:0]       rdB;
    } abd_mem_state_t;

    abd_mem_state_t state_r;
    abd_mem_state_t state_nxt;

    if (DEPTH * WIDTH > $bits(TGT_RST) || DEPTH > 2 ** ZW) begin : g_bad_size
        $error("abd_target_mem: reset image cannot fill this size");
    end

    always_comb
    begin
        state_nxt = state_r;
        if (we && waddr < DEPTH)
        begin
            state_nxt.mem[waddr*WIDTH +: WIDTH] = wdata;
        end
        state_nxt.rdA = (raddrA < DEPTH) ? state_r.mem[raddrA*WIDTH +: WIDTH] : '0;
        state_nxt.rdB = (raddrB < DEPTH) ? state_r.mem[raddrB*WIDTH +: WIDTH] : '0;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r     <= '0;
            state_r.mem <= TGT_RST[DEPTH*WIDTH-1:0];
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign rdataA = state_r.rdA;
    assign rdataB = state_r.rdB;
endmodule // abd_target_mem

/* File: tb/abd_avg_model.sv */
/*
 * Averager partner: one zone per averaging period, closed by a one-cycle tick.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/10ps
module abd_avg_model (
    input  wire logic         clk,
    output abd_pkg::abd_avg_t avgIn
);
    import abd_pkg::*;
    initial avgIn = '0;
    // The running zone moves at period start, so the tick always reports a settled zone.
    task automatic period(input logic [ZW-1:0] z, input int gap);
        @(posedge clk);
        avgIn.zone <= z;
        repeat (gap) @(posedge clk);
        avgIn.periodTick <= 1'b1;
        @(posedge clk);
        avgIn.periodTick <= 1'b0;
    endtask
    task automatic setZone(input logic [ZW-1:0] z);
        avgIn.zone <= z;
    endtask
endmodule // abd_avg_model

/* File: tb/tb.sv */
/*
 * Self-checking bench: AHB-Lite master tasks, averager partner and a zone decision model.
 * Assumes the decider is built with a short fast period of 20 cycles.
 */
`timescale 1ns/10ps
module tb;
    import abd_pkg::*;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    abd_ahb_req_t  req = '0;
    abd_ahb_rsp_t  rsp;
    abd_avg_t      avgIn;
    logic          fastStart, irqOe, irqOut;
    logic [ZW-1:0] avgZone, targetZone;
    logic [TW-1:0] blt;
    logic [31:0]   rd;
    int            errors = 0;
    int            cmp_count = 0;
    int            expAvg, expTgt, pend, cnt, lastDir, dd, code, z;
    bit            armed;
    logic [TW-1:0] tgt [NUM_ZONES] = '{8'h33, 8'h66, 8'h99, 8'hcc, 8'hff};
    logic [ZW-1:0] seq [12] = '{4, 3, 3, 2, 1, 2, 3, 3, 3, 4, 4, 4};

    always #4 clk = ~clk;

    abd_avg_model avgM (.clk(clk), .avgIn(avgIn));

    abd_decider #(.FAST_PERIOD_CYC(20)) DUT (
        .clk(clk), .rst_n(rst_n), .ahbReq(req), .hready(rsp.hreadyout), .ahbRsp(rsp),
        .avgIn(avgIn), .fastStart(fastStart), .avgZone(avgZone), .targetZone(targetZone),
        .backlightTarget(blt), .zoneIrqNIn(irqOe ? irqOut : 1'b1), .zoneIrqNOut(irqOut),
        .zoneIrqNOe(irqOe)
    );

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic test_done;
        $display("Compares %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Looking in the low phase means hready is settled before the edge that samples it.
    task automatic waitRdy;
        int n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (rsp.hreadyout !== 1'b1 && n < 50);
        if (n >= 50)
            chk("hready", 1, 0);
    endtask

    task automatic xfer(input logic wr, input logic [5:0] a, input logic [31:0] wd);
        req <= '{hsel: 1'b1, haddr: {26'h0, a}, htrans: 2'b10, hwrite: wr, hsize: 3'b010, hwdata: req.hwdata};
        waitRdy;
        @(posedge clk);
        req <= '{hsel: 1'b0, haddr: req.haddr, htrans: 2'b00, hwrite: wr, hsize: 3'b010, hwdata: wd};
        waitRdy;
        rd = rsp.hrdata;
        chk("hresp", 0, rsp.hresp);
        @(posedge clk);
    endtask

    task automatic start(input int mode, input int sz);
        int n = 0;
        avgM.setZone(3'(sz));
        xfer(1'b1, OFF_CTRL, 32'h0);
        xfer(1'b1, OFF_CTRL, (32'(mode) << CTRL_DD_BIT) | 32'h1);
        repeat (2) @(negedge clk);
        chk("fastStart", 1, fastStart);
        while (fastStart !== 1'b0 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk("fastLen", 1, 32'(n >= 55 && n < 65));
        chk("startTgt", sz, targetZone);
        expAvg = sz;
        expTgt = sz;
        pend   = 0;
        cnt    = 0;
        armed  = 1'b0;
        dd     = mode;
        @(posedge clk);
    endtask

    task automatic tick(input int nz, input int gap);
        int d;
        avgM.period(3'(nz), gap);
        d = nz > expAvg ? 1 : (nz < expAvg ? -1 : 0);
        expAvg = nz;
        if (armed)
        begin
            armed = 1'b0;
            if (d != 0 && d == lastDir)
            begin
                expTgt = nz;
                armed  = 1'b1;
            end
            else
            begin
                pend = d;
                cnt  = (d != 0) ? 1 : 0;
            end
        end
        else if (d != 0 && d != pend)
        begin
            pend = d;
            cnt  = 1;
        end
        else if (pend != 0)
            cnt++;
        if (!armed && pend != 0 && cnt >= ((pend < 0 && dd != 0) ? BASE_QUAL + DLY_EXTRA_BASE + code : BASE_QUAL))
        begin
            expTgt  = nz;
            armed   = 1'b1;
            lastDir = pend;
            pend    = 0;
            cnt     = 0;
        end
        @(negedge clk);
        chk("avgZone", expAvg, avgZone);
        chk("targetZone", expTgt, targetZone);
        @(negedge clk);
        chk("backlight", tgt[expTgt], blt);
        // Hand back just after a rising edge so that bus tasks may follow directly.
        @(posedge clk);
    endtask

    initial
    begin
        #(8 * 60000);
        chk("watchdog", 0, 1);
        test_done;
    end

    initial
    begin
        void'($urandom(52680));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("rstZone", 0, targetZone);
        chk("rstIrq", 0, irqOe);
        @(posedge clk);
        for (int i = 0; i < NUM_ZONES; i++)
        begin
            xfer(1'b0, OFF_TGT0 + 6'(4 * i), 32'h0);
            chk("tgtReset", tgt[i], rd);
        end
        xfer(1'b0, 6'h3c, 32'h0);
        chk("unmapped", 0, rd);
        tgt[2] = 8'($urandom);
        xfer(1'b1, OFF_TGT0 + 6'h08, 32'(tgt[2]));
        start(0, 4);
        xfer(1'b0, OFF_STAT, 32'h0);
        chk("status", 32'((1 << STAT_PIN_BIT) | (4 << STAT_TGT_LSB) | (4 << STAT_RUN_LSB) | (4 << STAT_AVG_LSB)), rd);
        foreach (seq[i]) tick(seq[i], 3);
        repeat (25) tick($urandom % 5, 1 + $urandom % 20);
        xfer(1'b0, OFF_INFO, 32'h0);
        z = (expAvg + 1) % 5;
        tick(z, 2);
        chk("irqSet", 1, irqOe);
        chk("irqPin", 0, irqOut);
        xfer(1'b0, OFF_STAT, 32'h0);
        chk("pinLevel", 0, rd[STAT_PIN_BIT]);
        xfer(1'b0, OFF_INFO, 32'h0);
        chk("zoneInfo", {1'b1, 3'(z)}, rd[3:0]);
        @(negedge clk);
        chk("irqClr", 0, irqOe);
        @(posedge clk);
        xfer(1'b0, OFF_INFO, 32'h0);
        chk("flagClr", 0, rd[INFO_FLAG_BIT]);
        xfer(1'b1, OFF_CTRL, 32'h0);
        avgM.setZone(3'((z + 2) % 5));
        repeat (3) @(negedge clk);
        chk("irqOff", 0, irqOe);
        @(posedge clk);
        for (int k = 0; k < 2; k++)
        begin
            code = k == 0 ? $urandom % 4 : 31;
            xfer(1'b1, OFF_DLY, 32'(code));
            start(1, 4);
            repeat (3 + code) tick(3, 2);
            tick(4, 2);
            repeat (7 + code) tick(2, 2);
            repeat (4) tick(4, 2);
            repeat (20) tick($urandom % 5, 1 + $urandom % 6);
        end
        test_done;
    end
endmodule // tb
